// ===== bgl_cfg.svh
// Offsets, field positions, reset values and timing counts of the bus glue.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef BGL_CFG_SVH
`define BGL_CFG_SVH

// Register byte offsets.
`define BGL_ADR_CTRL 8'h00
`define BGL_ADR_STATUS 8'h04
`define BGL_ADR_SHIFTER 8'h08

// Control register fields and reset value.
`define BGL_CTRL_IRQ_EN 0
`define BGL_CTRL_RESET 1'h1

// Status register fields.
`define BGL_ST_IRQ 0
`define BGL_ST_LOAD 1
`define BGL_ST_RX_READY 2
`define BGL_ST_TX_READY 3
`define BGL_ST_TRIG 4
`define BGL_ST_CLR 5
`define BGL_ST_BUSY 6
`define BGL_ST_CLR_INT 7

// Positions in the synchronised pin vector.
`define BGL_PIN_W 19
`define BGL_P_DATA 0
`define BGL_P_CLR 7
`define BGL_P_TRIG 8
`define BGL_P_SERIAL_POLL_TX_ENABLE 9
`define BGL_P_TE1 10
`define BGL_P_TALK 11
`define BGL_P_LISTEN 12
`define BGL_P_TXHS_N 13
`define BGL_P_RXHS_N 14
`define BGL_P_TXREQ 15
`define BGL_P_CPU_OUT 16
`define BGL_P_T3 17
`define BGL_P_T2 18
// Synchroniser reset value: both handshakes idle high, so no false edge.
`define BGL_PIN_IDLE 19'h06000

// One-shot hold-off after the switch to shift, in ns and in clock cycles.
`define BGL_CLK_MHZ 125
`define BGL_ONESHOT_NS 20000
`define BGL_ONESHOT_CYC ((`BGL_ONESHOT_NS * `BGL_CLK_MHZ) / 1000)
`define BGL_TMR_W 16

`endif

// ===== bgl_far.sv
// Far-side model: interface chip levels and isolated CPU pulses.
// Assumes its caller sits just after a rising MCLK edge.
`timescale 1ns/10ps
`default_nettype none
module bgl_far (
    // Clock.
    input wire logic MCLK,
    // Isolated CPU side.
    output logic SHIFT_CLOCK_PULSE,
    output logic SECONDARY_ISOLATOR_PULSE,
    output logic CPU_SERIAL_OUTPUT,
    output logic TX_READY_REQ,
    // Interface chip side.
    output logic RX_HANDSHAKE_N,
    output logic TX_HANDSHAKE_N,
    output logic LISTEN,
    output logic TALK,
    output logic TALK_ENABLE,
    output logic SERIAL_POLL_TX_ENABLE,
    output logic TRIGGER_PULSE,
    output logic CLEAR_PULSE,
    output logic [6:0] BUS_DATA_IN
);
    logic drive = 1'b0;
    logic [6:0] byte_q = 7'h00;
    initial begin
        {SHIFT_CLOCK_PULSE, SECONDARY_ISOLATOR_PULSE} = 2'h0;
        {CPU_SERIAL_OUTPUT, TX_READY_REQ, LISTEN, TALK} = 4'h0;
        {TALK_ENABLE, SERIAL_POLL_TX_ENABLE} = 2'h0;
        {TRIGGER_PULSE, CLEAR_PULSE} = 2'h0;
        {RX_HANDSHAKE_N, TX_HANDSHAKE_N} = 2'h3;
        BUS_DATA_IN = 7'h00;
    end
    // Undriven data lines flip every cycle so a stale value never passes.
    always @(posedge MCLK) begin
        BUS_DATA_IN <= drive ? byte_q : ~BUS_DATA_IN;
    end
    // The link pulses run at 160 ns and stand still between commands.
    task automatic iso(input logic t2, input logic t3);
        SHIFT_CLOCK_PULSE <= t2;
        SECONDARY_ISOLATOR_PULSE <= t3;
        repeat (10) @(posedge MCLK);
        SHIFT_CLOCK_PULSE <= 1'b0;
        SECONDARY_ISOLATOR_PULSE <= 1'b0;
        repeat (10) @(posedge MCLK);
    endtask : iso
    task automatic strobe(input logic req, input logic trig);
        TX_READY_REQ <= req;
        TRIGGER_PULSE <= trig;
        repeat (10) @(posedge MCLK);
        TX_READY_REQ <= 1'b0;
        TRIGGER_PULSE <= 1'b0;
        repeat (10) @(posedge MCLK);
    endtask : strobe
    task automatic present(input logic [6:0] d);
        byte_q <= d;
        drive <= 1'b1;
        @(posedge MCLK);
        RX_HANDSHAKE_N <= 1'b0;
    endtask : present
    task automatic release_byte;
        RX_HANDSHAKE_N <= 1'b1;
        @(posedge MCLK);
        drive <= 1'b0;
    endtask : release_byte
    task automatic tx_hold(input logic on);
        TX_HANDSHAKE_N <= !on;
    endtask : tx_hold
endmodule : bgl_far
`default_nettype wire

// ===== bgl_glue.sv
// Glue between a parallel instrument-bus interface chip and an isolated CPU.
// Assumes all pin inputs are asynchronous to MCLK and a Wishbone master.
`timescale 1ns/10ps
`default_nettype none
`include "bgl_cfg.svh"

module bgl_glue (
    // System.
    input wire logic MCLK,
    input wire logic RST,
    // Wishbone slave.
    input wire logic [7:0] WB_ADR_I,
    input wire bgl_pkg::bgl_word_t WB_DAT_I,
    output bgl_pkg::bgl_word_t WB_DAT_O,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic WB_ACK_O,
    // Isolated CPU side.
    input wire logic SHIFT_CLOCK_PULSE,
    input wire logic SECONDARY_ISOLATOR_PULSE,
    input wire logic CPU_SERIAL_OUTPUT,
    input wire logic TX_READY_REQ,
    output logic CPU_SERIAL_INPUT,
    output logic BUS_STATUS_IRQ,
    output logic LOAD_SELECT,
    // Interface chip handshakes and state.
    input wire logic RX_HANDSHAKE_N,
    input wire logic TX_HANDSHAKE_N,
    input wire logic LISTEN,
    input wire logic TALK,
    input wire logic TALK_ENABLE,
    input wire logic SERIAL_POLL_TX_ENABLE,
    input wire logic TRIGGER_PULSE,
    input wire logic CLEAR_PULSE,
    output logic RX_READY,
    output logic TX_READY,
    // Bus data lines 1 to 7 in, and the driven lines.
    input wire logic [6:0] BUS_DATA_IN,
    output logic DIO7_O,
    output logic DIO7_OE,
    output logic DIO8_O,
    output logic DIO8_OE,
    output logic EOI_O,
    output logic EOI_OE
);
    import bgl_pkg::*;

    // Every pin is synchronised; stage s1 feeds s2 only.
    logic [`BGL_PIN_W-1:0] s1, s2, s3;
    wire [`BGL_PIN_W-1:0] pin_raw = {SHIFT_CLOCK_PULSE,
        SECONDARY_ISOLATOR_PULSE, CPU_SERIAL_OUTPUT, TX_READY_REQ,
        RX_HANDSHAKE_N, TX_HANDSHAKE_N, LISTEN, TALK, TALK_ENABLE,
        SERIAL_POLL_TX_ENABLE, TRIGGER_PULSE, CLEAR_PULSE, BUS_DATA_IN};
    wire [`BGL_PIN_W-1:0] rise = s2 & ~s3;
    wire [`BGL_PIN_W-1:0] fall = ~s2 & s3;
    wire [`BGL_PIN_W-1:0] edge_any = s2 ^ s3;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            // Stages start at the pins' idle levels so release makes no edge.
            s1 <= `BGL_PIN_IDLE;
            s2 <= `BGL_PIN_IDLE;
            s3 <= `BGL_PIN_IDLE;
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    wire t2 = s2[`BGL_P_T2];
    wire t3 = s2[`BGL_P_T3];
    wire t2_rise = rise[`BGL_P_T2];
    wire t3_rise = rise[`BGL_P_T3];
    wire listen = s2[`BGL_P_LISTEN];
    wire talk = s2[`BGL_P_TALK];
    wire te1 = s2[`BGL_P_TE1];
    wire serial_poll_tx_enable = s2[`BGL_P_SERIAL_POLL_TX_ENABLE];
    wire rx_hs = ~s2[`BGL_P_RXHS_N];
    wire rx_hs_fall = fall[`BGL_P_RXHS_N];
    wire tx_hs_fall = fall[`BGL_P_TXHS_N];
    wire tx_req_rise = rise[`BGL_P_TXREQ];
    wire trig_rise = rise[`BGL_P_TRIG];
    wire clr_rise_in = rise[`BGL_P_CLR];

    // Register state.
    logic ctrl_irq_en;
    logic irq_flag, clr_int, clr_int_q;
    logic trig_cap, clr_cap, trig_snap, clr_snap, trig_again, clr_again;
    logic load_q, pending, rx_ready, tx_ready;
    logic [`BGL_TMR_W-1:0] tmr;
    bgl_sel_t sel;
    bgl_byte_t shifter;

    // Monitored status lines: a move of any of them is a change, except RX handshake (fall only) and trigger and clear (rise only).
    wire state_change = |{edge_any[`BGL_P_LISTEN], edge_any[`BGL_P_TALK],
        edge_any[`BGL_P_TE1], edge_any[`BGL_P_SERIAL_POLL_TX_ENABLE], rx_hs_fall,
        edge_any[`BGL_P_TXHS_N], trig_rise, clr_rise_in};
    wire change_pulse = state_change & ctrl_irq_en;
    wire clr_int_rise = clr_int & ~clr_int_q;
    wire load_rise = (sel == BGL_LOAD) & ~load_q;
    wire busy = (tmr != '0);

    // Byte source selection.
    wire data_en_n = ~(~talk & rx_hs);
    wire [6:0] status_bits = {clr_cap, trig_cap, serial_poll_tx_enable, te1, talk, listen,
        rx_hs};
    wire bgl_byte_t mux_byte = data_en_n ? {status_bits, 1'b0}
        : {s2[`BGL_P_DATA +: 7], ~data_en_n};
    wire bgl_byte_t shift_byte = {s2[`BGL_P_CPU_OUT], shifter[7:1]};

    // Interrupt flag and the clear pulse that needs both isolator pulses.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            clr_int <= 1'b0;
            clr_int_q <= 1'b0;
            irq_flag <= 1'b0;
        end else begin
            clr_int <= clr_int ? (t2 | t3) : (t2 & t3);
            clr_int_q <= clr_int;
            if (change_pulse)
                irq_flag <= 1'b1;
            else if (clr_int_rise)
                irq_flag <= 1'b0;
        end
    end

    // Load/shift select with the one-shot hold-off.
    // The timer is retriggered by every shift while it runs, so a slow CPU keeps it busy.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sel <= BGL_LOAD;
            load_q <= 1'b1;
            pending <= 1'b0;
            tmr <= '0;
        end else begin
            load_q <= (sel == BGL_LOAD);
            if (clr_int_rise) begin
                sel <= BGL_SHIFT;
                tmr <= `BGL_TMR_W'(`BGL_ONESHOT_CYC);
                pending <= change_pulse;
            end else if (sel == BGL_SHIFT && (busy || pending)) begin
                if (t2_rise)
                    tmr <= `BGL_TMR_W'(`BGL_ONESHOT_CYC);
                else if (busy)
                    tmr <= tmr - 1'b1;
                if (change_pulse)
                    pending <= 1'b1;
                else if (!busy) begin
                    sel <= BGL_LOAD;
                    pending <= 1'b0;
                end
            end else if (change_pulse) begin
                sel <= BGL_LOAD;
            end
        end
    end

    // Trigger and clear captures, protected against a pulse that arrives
    // between the interrupt and the load edge.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            trig_cap <= 1'b0;
            clr_cap <= 1'b0;
            trig_snap <= 1'b0;
            clr_snap <= 1'b0;
            trig_again <= 1'b0;
            clr_again <= 1'b0;
        end else begin
            if (change_pulse) begin
                trig_snap <= trig_cap | trig_rise;
                clr_snap <= clr_cap | clr_rise_in;
            end
            trig_again <= (load_rise | change_pulse) ? 1'b0
                : (trig_again | trig_rise);
            clr_again <= (load_rise | change_pulse) ? 1'b0
                : (clr_again | clr_rise_in);
            if (trig_rise)
                trig_cap <= 1'b1;
            else if (load_rise && trig_snap && !trig_again)
                trig_cap <= 1'b0;
            if (clr_rise_in)
                clr_cap <= 1'b1;
            else if (load_rise && clr_snap && !clr_again)
                clr_cap <= 1'b0;
        end
    end

    // Shifter: bit 0 is the first bit seen by the CPU serial input.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            shifter <= '0;
        end else if (t2_rise) begin
            shifter <= (sel == BGL_LOAD) ? mux_byte : shift_byte;
        end
    end

    // Receive-ready in its three modes.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            rx_ready <= 1'b0;
        end else if (listen && te1) begin
            if (rx_hs_fall)
                rx_ready <= 1'b1;
        end else if (rise[`BGL_P_LISTEN] && !te1) begin
            rx_ready <= 1'b1;
        end else if (sel == BGL_SHIFT && t3_rise) begin
            rx_ready <= ~rx_ready;
        end
    end

    // Transmit-ready: the CPU request wins over a reset in the same cycle.
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            tx_ready <= 1'b0;
        end else if (tx_req_rise) begin
            tx_ready <= 1'b1;
        end else if (tx_hs_fall || edge_any[`BGL_P_TE1]) begin
            tx_ready <= 1'b0;
        end
    end

    // Registered pin outputs.
    wire drive_en = te1 | serial_poll_tx_enable;
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            CPU_SERIAL_INPUT <= 1'b0;
            BUS_STATUS_IRQ <= 1'b0;
            LOAD_SELECT <= 1'b1;
            RX_READY <= 1'b0;
            TX_READY <= 1'b0;
            DIO7_O <= 1'b0;
            DIO7_OE <= 1'b0;
            DIO8_O <= 1'b1;
            DIO8_OE <= 1'b0;
            EOI_O <= 1'b0;
            EOI_OE <= 1'b0;
        end else begin
            CPU_SERIAL_INPUT <= shifter[0];
            BUS_STATUS_IRQ <= irq_flag;
            LOAD_SELECT <= (sel == BGL_LOAD);
            RX_READY <= rx_ready;
            TX_READY <= tx_ready;
            DIO7_O <= shifter[6];
            DIO7_OE <= drive_en & ~serial_poll_tx_enable;
            DIO8_O <= serial_poll_tx_enable ? shifter[7] : 1'b1;
            DIO8_OE <= drive_en;
            EOI_O <= shifter[7];
            EOI_OE <= te1 & ~serial_poll_tx_enable;
        end
    end

    // Wishbone slave: one wait state, ack for one cycle, unmapped reads 0.
    wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire hit_ctrl = (WB_ADR_I == `BGL_ADR_CTRL);
    wire [7:0] st_bits = {clr_int, busy, clr_cap, trig_cap, tx_ready,
        rx_ready, (sel == BGL_LOAD), irq_flag};
    wire bgl_word_t rd_data;
    assign rd_data = hit_ctrl ? {31'h0, ctrl_irq_en}
        : (WB_ADR_I == `BGL_ADR_STATUS) ? {24'h0, st_bits}
        : (WB_ADR_I == `BGL_ADR_SHIFTER) ? {24'h0, shifter}
        : 32'h0;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
            ctrl_irq_en <= `BGL_CTRL_RESET;
        end else begin
            WB_ACK_O <= req;
            WB_DAT_O <= req ? rd_data : 32'h0;
            if (req && WB_WE_I && hit_ctrl && WB_SEL_I[0])
                ctrl_irq_en <= WB_DAT_I[`BGL_CTRL_IRQ_EN];
        end
    end

    // Checks.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_irq_set_change: assert property (change_pulse |=> irq_flag)
        else $error("interrupt flag not set by change");
    a_irq_clear: assert property (clr_int_rise && !change_pulse
        |=> !irq_flag)
        else $error("interrupt flag not reset by clear");
    a_clr_start: assert property ($rose(clr_int) |-> $past(t2) && $past(t3))
        else $error("clear pulse began without both pulses");
    a_clr_end: assert property ($fell(clr_int) |-> !$past(t2) && !$past(t3))
        else $error("clear pulse ended while a pulse was high");
    a_tx_set: assert property (tx_req_rise |=> tx_ready ##1 TX_READY)
        else $error("transmit ready not set");
    a_tx_reset: assert property (tx_hs_fall && !tx_req_rise
        |=> !tx_ready)
        else $error("transmit ready not reset by handshake");
    a_tx_talker: assert property (edge_any[`BGL_P_TE1] && !tx_req_rise
        |=> !tx_ready)
        else $error("transmit ready not reset by talker change");
    a_poll_line7: assert property (serial_poll_tx_enable |=> !DIO7_OE)
        else $error("line 7 driven during serial poll");
    a_hold_off: assert property (busy && sel == BGL_SHIFT
        |=> sel == BGL_SHIFT)
        else $error("select returned to load while busy");
    a_first_bit: assert property (sel == BGL_LOAD && t2_rise
        |=> shifter[0] == $past(~data_en_n))
        else $error("first loaded bit wrong");
    a_dio8_high: assert property (!$past(serial_poll_tx_enable) |-> DIO8_O)
        else $error("line 8 not high outside serial poll");
    a_wb_ack: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus ack not a single cycle");

    c_irq_cycle: cover property (irq_flag ##[1:1000] clr_int_rise);
    c_shift_out: cover property (sel == BGL_SHIFT && t2_rise);
    c_tx_cycle: cover property (tx_req_rise ##[1:1000] tx_hs_fall);
    c_self_talk: cover property (listen && te1 && rx_hs_fall);
    c_gated: cover property (state_change && !ctrl_irq_en);
endmodule : bgl_glue
`default_nettype wire

// ===== bgl_pkg.sv
// Types shared by the bus glue logic.
// Holds its own widths; takes no constants from bgl_cfg.svh.
package bgl_pkg;
    typedef enum logic {BGL_LOAD, BGL_SHIFT} bgl_sel_t;
    typedef logic [7:0] bgl_byte_t;
    typedef logic [31:0] bgl_word_t;
endpackage : bgl_pkg

// ===== bus_to_cpu_glue_logic_bench.sv
// Self-checking bench for the bus glue, one task per scenario.
// Assumes bgl_glue and the far-side model bgl_far.
`timescale 1ns/10ps
`default_nettype none
module bus_to_cpu_glue_logic_bench;
    import bgl_pkg::*;
    logic MCLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] wb_adr = 8'h00;
    bgl_word_t wb_dat = 32'h0;
    bgl_word_t wb_rdat;
    bgl_word_t rd;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_ack, t2, t3, sout, txq, rxh, txh, lis, tlk, te1, spe, trg, clr;
    logic [6:0] bd;
    logic sin, irq, load, rxr, txr, d7, d7e, d8, d8e, eoi, eoie;
    int miscompares = 0;
    int num_checks = 0;
    bgl_glue dut (.MCLK(MCLK), .RST(RST), .WB_ADR_I(wb_adr),
        .WB_DAT_I(wb_dat), .WB_DAT_O(wb_rdat), .WB_WE_I(wb_we),
        .WB_SEL_I(4'hf), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
        .WB_ACK_O(wb_ack), .SHIFT_CLOCK_PULSE(t2),
        .SECONDARY_ISOLATOR_PULSE(t3), .CPU_SERIAL_OUTPUT(sout),
        .TX_READY_REQ(txq), .CPU_SERIAL_INPUT(sin), .BUS_STATUS_IRQ(irq),
        .LOAD_SELECT(load), .RX_HANDSHAKE_N(rxh), .TX_HANDSHAKE_N(txh),
        .LISTEN(lis), .TALK(tlk), .TALK_ENABLE(te1),
        .SERIAL_POLL_TX_ENABLE(spe), .TRIGGER_PULSE(trg), .CLEAR_PULSE(clr),
        .RX_READY(rxr), .TX_READY(txr), .BUS_DATA_IN(bd), .DIO7_O(d7),
        .DIO7_OE(d7e), .DIO8_O(d8), .DIO8_OE(d8e), .EOI_O(eoi),
        .EOI_OE(eoie));
    bgl_far far (.MCLK(MCLK), .SHIFT_CLOCK_PULSE(t2),
        .SECONDARY_ISOLATOR_PULSE(t3), .CPU_SERIAL_OUTPUT(sout),
        .TX_READY_REQ(txq), .RX_HANDSHAKE_N(rxh), .TX_HANDSHAKE_N(txh),
        .LISTEN(lis), .TALK(tlk), .TALK_ENABLE(te1),
        .SERIAL_POLL_TX_ENABLE(spe), .TRIGGER_PULSE(trg),
        .CLEAR_PULSE(clr), .BUS_DATA_IN(bd));
    initial begin
        forever #4 MCLK = ~MCLK;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic settle;
        repeat (8) @(posedge MCLK);
    endtask : settle
    task automatic wait_load(output int n);
        n = 0;
        while (load !== 1'b1 && n < 4000) begin
            @(posedge MCLK);
            n++;
        end
        if (n >= 4000) begin
            miscompares++;
            wrap_up();
        end
    endtask : wait_load
    // Classic single cycle; the request stands until ack is sampled high.
    task automatic wb_xfer(input logic we, input logic [7:0] adr,
                           input bgl_word_t dat);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= dat;
        do begin
            @(posedge MCLK);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge MCLK);
        if (n >= 20) begin
            miscompares++;
            wrap_up();
        end
    endtask : wb_xfer
    task automatic rd_reg(input logic [7:0] adr);
        wb_xfer(1'b0, adr, 32'h0);
    endtask : rd_reg
    task automatic test_reset;
        chk("load", 1'b1, load);
        chk("irq", 1'b0, irq);
        chk("tx ready", 1'b0, txr);
        chk("line 8 idle", 1'b1, d8);
        chk("enables", 3'h0, {d7e, d8e, eoie});
    endtask : test_reset
    task automatic test_regs;
        // Handshakes idle high match the synchroniser reset: no change seen.
        rd_reg(8'h04);
        chk("status", 32'h2, rd);
        wb_xfer(1'b1, 8'h00, 32'h0);
        rd_reg(8'h00);
        chk("irq enable off", 32'h0, rd);
        far.TALK <= 1'b1;
        settle();
        chk("irq gated", 1'b0, irq);
        far.TALK <= 1'b0;
        settle();
        wb_xfer(1'b1, 8'h00, 32'h1);
        rd_reg(8'h00);
        chk("irq enable on", 32'h1, rd);
        rd_reg(8'h0c);
        chk("unmapped", 32'h0, rd);
    endtask : test_regs
    task automatic test_tx;
        far.strobe(1'b1, 1'b0);
        chk("tx set", 1'b1, txr);
        far.tx_hold(1'b1);
        settle();
        chk("tx handshake", 1'b0, txr);
        chk("irq set by change", 1'b1, irq);
        far.tx_hold(1'b0);
        far.strobe(1'b1, 1'b0);
        far.TALK_ENABLE <= 1'b1;
        settle();
        chk("tx talker change", 1'b0, txr);
        far.TALK_ENABLE <= 1'b0;
        settle();
    endtask : test_tx
    task automatic test_listen;
        int n;
        // Clear first so that the flag and the select both have to move.
        far.iso(1'b1, 1'b1);
        chk("irq clear first", 1'b0, irq);
        far.LISTEN <= 1'b1;
        settle();
        chk("rx preset", 1'b1, rxr);
        chk("irq on change", 1'b1, irq);
        chk("select held busy", 1'b0, load);
        wait_load(n);
        chk("load on change", 1'b1, load);
    endtask : test_listen
    task automatic test_shift;
        far.present(7'h55);
        settle();
        far.iso(1'b1, 1'b0);
        rd_reg(8'h08);
        chk("data byte", 32'hab, rd);
        far.iso(1'b1, 1'b1);
        chk("irq cleared", 1'b0, irq);
        chk("select shift", 1'b0, load);
        for (int i = 0; i < 8; i++) begin
            chk("serial out", 8'hab >> i & 8'h1, sin);
            far.CPU_SERIAL_OUTPUT <= 1'((8'h43 >> i) & 8'h1);
            repeat (4) @(posedge MCLK);
            far.iso(1'b1, 1'b0);
        end
        rd_reg(8'h08);
        chk("shifted in", 32'h43, rd);
        far.iso(1'b0, 1'b1);
        chk("rx toggled", 1'b0, rxr);
    endtask : test_shift
    task automatic test_drive;
        far.TALK_ENABLE <= 1'b1;
        settle();
        chk("talk drive", 6'h3e, {d7e, d7, d8e, d8, eoie, eoi});
        far.SERIAL_POLL_TX_ENABLE <= 1'b1;
        settle();
        chk("poll drive", 6'h18, {d7e, d7, d8e, d8, eoie, eoi});
        far.SERIAL_POLL_TX_ENABLE <= 1'b0;
        far.release_byte();
        settle();
        far.present(7'h55);
        settle();
        chk("rx self set", 1'b1, rxr);
        far.TALK_ENABLE <= 1'b0;
        settle();
        chk("idle drive", 3'h0, {d7e, d8e, eoie});
    endtask : test_drive
    task automatic test_status;
        int n;
        far.strobe(1'b0, 1'b1);
        chk("select held", 1'b0, load);
        wait_load(n);
        chk("hold-off", 1'b1, n > 1500);
        far.release_byte();
        settle();
        rd_reg(8'h04);
        chk("status after load", 32'h7, rd);
        far.iso(1'b1, 1'b0);
        rd_reg(8'h08);
        chk("status byte", 32'h04, rd);
    endtask : test_status
    initial begin
        repeat (9) @(posedge MCLK);
        test_reset();
        @(posedge MCLK);
        RST <= 1'b0;
        settle();
        test_regs();
        test_tx();
        test_listen();
        test_shift();
        test_drive();
        test_status();
        wrap_up();
    end
endmodule : bus_to_cpu_glue_logic_bench
`default_nettype wire
